// ===== rtl/genset_seq_map.vh
// constants for the dual genset standby sequencer
// Behaviour
// - no start outputs without standby request
// - request starts preferred genset immediately
// - preferred fails: engine start delay, start backup
// - connect load only to available genset
// - preferred returns: retransfer delay, move back
// - after retransfer, cool down then stop backup
// - request withdrawn: cool down, stop active genset
// - preferred change transfers when needed and available
// - alternation: each later outage swaps preferred
// - toggle on outage, lead tests or expiry of the alternation period
// - backup takeover keeps preferred unchanged
// - alternation period limited to two weeks
// - alternation period in one-hour steps
// - running preferred fails: start backup, transfer
// - preferred change: cool down old preferred
// - lamp test lights all indicators
// - programmable delays, defaults 3 s and 600 s
`ifndef GENSET_SEQ_MAP_VH
`define GENSET_SEQ_MAP_VH
`define CLK_HZ 25000000
`define TICK_DIV (`CLK_HZ)
`define START_DLY_SEC 16'h0003
`define RETRANS_DLY_SEC 16'h0258
`define COOL_DLY_SEC 16'h0258
`define ALT_MAX_HOURS 16'h0150
`define SEC_PER_HOUR 16'h0E10
`define ADDR_START_DLY 4'h0
`define ADDR_RETRANS_DLY 4'h1
`define ADDR_COOL_DLY 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_ALT_HOURS 4'h4
`define ADDR_STATUS 4'h5
`define CTRL_PREF_BIT 0
`define CTRL_ALT_EN_BIT 1
`endif

// ===== rtl/genset_seq.v
// dual genset standby sequencer with a small register port
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "genset_seq_map.vh"
module genset_seq #(
	parameter TICK_DIV = `TICK_DIV
)
(
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// register port
	input wire [3:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [15:0] rdata_out,
	// sources and requests
	input wire standby_start_request_in,
	input wire avail_one_in,
	input wire avail_two_in,
	input wire lead_test_in,
	input wire lamp_test_in,
	// genset control
	output reg start_one_out,
	output reg start_two_out,
	output reg connect_one_out,
	output reg connect_two_out,
	output wire [3:0] lamps_out
);
	localparam ST_IDLE = 3'd0;
	localparam ST_PREF_START = 3'd1;
	localparam ST_PREF_RUN = 3'd2;
	localparam ST_BACK_RUN = 3'd3;
	localparam ST_RETRANS = 3'd4;
	localparam ST_COOL_OTHER = 3'd5;
	localparam ST_STOP_COOL = 3'd6;

	reg [15:0] start_dly_r;
	reg [15:0] retrans_dly_r;
	reg [15:0] cool_dly_r;
	reg [15:0] alt_hours_r;
	reg pref_r;
	reg alt_en_r;
	reg [2:0] state_r;
	reg [15:0] tmr_r;
	reg [24:0] div_r;
	reg tick_r;
	reg req_d_r;
	reg test_d_r;
	reg first_out_r;
	reg [15:0] alt_sec_r;
	reg [15:0] alt_hr_r;
	wire avail_pref;
	wire avail_back;
	wire outage_ev;
	wire tmr_done;

	assign avail_pref = pref_r ? avail_two_in : avail_one_in;
	assign avail_back = pref_r ? avail_one_in : avail_two_in;
	assign outage_ev = (standby_start_request_in & ~req_d_r) | (lead_test_in & ~test_d_r);
	assign tmr_done = (tmr_r == 16'h0000);
	assign lamps_out = lamp_test_in ? 4'hF :
		{connect_two_out, connect_one_out, start_two_out, start_one_out};

	// one-second tick from the system clock
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			div_r <= 25'd0;
			tick_r <= 1'b0;
		end
		else if (div_r == TICK_DIV - 1)
		begin
			div_r <= 25'd0;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 25'd1;
			tick_r <= 1'b0;
		end
	end

	// registers; alternation enable only here, front panel has no path to it
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			start_dly_r <= `START_DLY_SEC;
			retrans_dly_r <= `RETRANS_DLY_SEC;
			cool_dly_r <= `COOL_DLY_SEC;
			alt_hours_r <= `ALT_MAX_HOURS;
			alt_en_r <= 1'b0;
		end
		else if (wr_in)
		begin
			case (addr_in)
				`ADDR_START_DLY: start_dly_r <= wdata_in;
				`ADDR_RETRANS_DLY: retrans_dly_r <= wdata_in;
				`ADDR_COOL_DLY: cool_dly_r <= wdata_in;
				`ADDR_CTRL: alt_en_r <= wdata_in[`CTRL_ALT_EN_BIT];
				`ADDR_ALT_HOURS: alt_hours_r <= (wdata_in > `ALT_MAX_HOURS) ?
					`ALT_MAX_HOURS : wdata_in;
				default: ;
			endcase
		end
	end

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rdata_out <= 16'h0000;
		else if (rd_in)
		begin
			case (addr_in)
				`ADDR_START_DLY: rdata_out <= start_dly_r;
				`ADDR_RETRANS_DLY: rdata_out <= retrans_dly_r;
				`ADDR_COOL_DLY: rdata_out <= cool_dly_r;
				`ADDR_CTRL: rdata_out <= {14'h0000, alt_en_r, pref_r};
				`ADDR_ALT_HOURS: rdata_out <= alt_hours_r;
				`ADDR_STATUS: rdata_out <= {9'h000, state_r, connect_two_out,
					connect_one_out, start_two_out, start_one_out};
				default: rdata_out <= 16'h0000;
			endcase
		end
		else
			rdata_out <= 16'h0000;
	end

	// sequencer
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_r <= ST_IDLE;
			tmr_r <= 16'h0000;
			pref_r <= 1'b0;
			req_d_r <= 1'b0;
			test_d_r <= 1'b0;
			first_out_r <= 1'b1;
			alt_sec_r <= 16'h0000;
			alt_hr_r <= 16'h0000;
			start_one_out <= 1'b0;
			start_two_out <= 1'b0;
			connect_one_out <= 1'b0;
			connect_two_out <= 1'b0;
		end
		else
		begin
			req_d_r <= standby_start_request_in;
			test_d_r <= lead_test_in;
			if (tick_r && !tmr_done)
				tmr_r <= tmr_r - 16'h0001;
			// manual preferred change: running path here; the plain idle write is below
			if (wr_in && addr_in == `ADDR_CTRL && wdata_in[`CTRL_PREF_BIT] != pref_r &&
				state_r != ST_IDLE)
			begin
				pref_r <= wdata_in[`CTRL_PREF_BIT];
				state_r <= ST_PREF_START;
			end
			else
			begin
				// an idle write still lets a coinciding outage through, and the outage wins
				if (wr_in && addr_in == `ADDR_CTRL && state_r == ST_IDLE)
					pref_r <= wdata_in[`CTRL_PREF_BIT];
				if (outage_ev && alt_en_r)
				begin
					if (first_out_r)
						first_out_r <= 1'b0;
					else
					begin
						pref_r <= ~pref_r;
						// a lead test while running hands over like a manual change
						if (state_r == ST_PREF_RUN)
							state_r <= ST_PREF_START;
					end
					alt_sec_r <= 16'h0000;
					alt_hr_r <= 16'h0000;
				end
				else if (alt_en_r && tick_r && state_r == ST_PREF_RUN)
				begin
					// period cap, counted only while the preferred carries the load
					// so that a changeover never cuts into another handover
					if (alt_sec_r == `SEC_PER_HOUR - 16'h0001)
					begin
						alt_sec_r <= 16'h0000;
						if (alt_hr_r + 16'h0001 >= alt_hours_r)
						begin
							alt_hr_r <= 16'h0000;
							pref_r <= ~pref_r;
							state_r <= ST_PREF_START;
						end
						else
							alt_hr_r <= alt_hr_r + 16'h0001;
					end
					else
						alt_sec_r <= alt_sec_r + 16'h0001;
				end
				case (state_r)
					ST_IDLE:
					begin
						start_one_out <= 1'b0;
						start_two_out <= 1'b0;
						connect_one_out <= 1'b0;
						connect_two_out <= 1'b0;
						if (standby_start_request_in)
						begin
							state_r <= ST_PREF_START;
							tmr_r <= start_dly_r;
						end
					end
					ST_PREF_START:
					begin
						// preferred starts at once; old one keeps load until handover
						if (standby_start_request_in && pref_r)
							start_two_out <= 1'b1;
						else if (standby_start_request_in)
							start_one_out <= 1'b1;
						if (!standby_start_request_in)
						begin
							state_r <= ST_STOP_COOL;
							tmr_r <= cool_dly_r;
						end
						else if (avail_pref)
						begin
							connect_one_out <= ~pref_r;
							connect_two_out <= pref_r;
							if (connect_one_out | connect_two_out)
							begin
								state_r <= ST_COOL_OTHER;
								tmr_r <= cool_dly_r;
							end
							else
								state_r <= ST_PREF_RUN;
						end
						else if (tmr_done && !(connect_one_out | connect_two_out))
						begin
							// pref flag kept; backup only carries the load
							if (pref_r)
								start_one_out <= 1'b1;
							else
								start_two_out <= 1'b1;
							state_r <= ST_BACK_RUN;
						end
					end
					ST_PREF_RUN:
					begin
						if (!standby_start_request_in)
						begin
							state_r <= ST_STOP_COOL;
							tmr_r <= cool_dly_r;
						end
						else if (!avail_pref)
						begin
							connect_one_out <= 1'b0;
							connect_two_out <= 1'b0;
							if (pref_r)
								start_one_out <= 1'b1;
							else
								start_two_out <= 1'b1;
							state_r <= ST_BACK_RUN;
						end
					end
					ST_BACK_RUN:
					begin
						if (avail_back && !(connect_one_out | connect_two_out))
						begin
							connect_one_out <= pref_r;
							connect_two_out <= ~pref_r;
						end
						if (!standby_start_request_in)
						begin
							state_r <= ST_STOP_COOL;
							tmr_r <= cool_dly_r;
						end
						else if (avail_pref)
						begin
							state_r <= ST_RETRANS;
							tmr_r <= retrans_dly_r;
						end
					end
					ST_RETRANS:
					begin
						if (!standby_start_request_in)
						begin
							state_r <= ST_STOP_COOL;
							tmr_r <= cool_dly_r;
						end
						else if (!avail_pref)
							state_r <= ST_BACK_RUN;
						else if (tmr_done)
						begin
							connect_one_out <= ~pref_r;
							connect_two_out <= pref_r;
							state_r <= ST_COOL_OTHER;
							tmr_r <= cool_dly_r;
						end
					end
					ST_COOL_OTHER:
					begin
						if (tmr_done)
						begin
							if (pref_r)
								start_one_out <= 1'b0;
							else
								start_two_out <= 1'b0;
							state_r <= standby_start_request_in ? ST_PREF_RUN : ST_STOP_COOL;
							tmr_r <= cool_dly_r;
						end
					end
					ST_STOP_COOL:
					begin
						if (standby_start_request_in)
							state_r <= ST_PREF_START;
						else if (tmr_done)
						begin
							start_one_out <= 1'b0;
							start_two_out <= 1'b0;
							connect_one_out <= 1'b0;
							connect_two_out <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// ===== verif/genset_seq_checker.sv
// port assertions for the genset sequencer
`timescale 1ns/100ps
module genset_seq_checker #(parameter TICK_DIV = 25000000)
(
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// watched ports
	input wire rd_in,
	input wire [15:0] rdata_out,
	input wire standby_start_request_in,
	input wire avail_one_in,
	input wire avail_two_in,
	input wire lamp_test_in,
	input wire start_one_out,
	input wire start_two_out,
	input wire connect_one_out,
	input wire connect_two_out,
	input wire [3:0] lamps_out
);
	wire run = start_one_out | start_two_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	chk_start_needs_req: assert property ($rose(run) |-> $past(standby_start_request_in))
		else $error("start without request");
	chk_req_starts: assert property ($rose(standby_start_request_in) && !run |-> ##[1:2] run)
		else $error("request not served");
	chk_conn_one_ok: assert property ($rose(connect_one_out) |-> $past(avail_one_in))
		else $error("one connected unavailable");
	chk_conn_two_ok: assert property ($rose(connect_two_out) |-> $past(avail_two_in))
		else $error("two connected unavailable");
	chk_single_load: assert property (!(connect_one_out && connect_two_out))
		else $error("both connected");
	chk_cool_hold: assert property ($fell(standby_start_request_in) && run |=> run[*8])
		else $error("stopped without cool-down");
	chk_backup_cool: assert property ($rose(connect_one_out) && start_two_out |=> start_two_out[*8])
		else $error("backup stopped early");
	chk_lamp_all: assert property (lamp_test_in |-> lamps_out == 4'hF)
		else $error("lamp test dark");
	chk_lamp_map: assert property (!lamp_test_in |->
		lamps_out == {connect_two_out, connect_one_out, start_two_out, start_one_out})
		else $error("lamps wrong");
	chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
		else $error("read data stale");
	cover property ($rose(connect_two_out));
	cover property ($rose(connect_one_out) && start_two_out);
	cover property ($fell(standby_start_request_in) && run);
endmodule
bind genset_seq genset_seq_checker #(.TICK_DIV(TICK_DIV)) genset_seq_checker_i (
	.clk_in(clk_in), .rstn_in(rstn_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.standby_start_request_in(standby_start_request_in), .avail_one_in(avail_one_in),
	.avail_two_in(avail_two_in), .lamp_test_in(lamp_test_in), .start_one_out(start_one_out),
	.start_two_out(start_two_out), .connect_one_out(connect_one_out),
	.connect_two_out(connect_two_out), .lamps_out(lamps_out));

// ===== verif/genset_pair_model.sv
// two gensets: in range a few cycles after a run command
`timescale 1ns/100ps
module genset_pair_model
(
	// inputs
	input wire clk_in,
	input wire start_one_in,
	input wire start_two_in,
	input wire fail_one_in,
	// availability
	output wire avail_one_out,
	output wire avail_two_out
);
	reg [1:0] up_one_r = 2'h0;
	reg [1:0] up_two_r = 2'h0;
	// flag drops at once on stop, or on fault for genset one only, so no stale availability is shown
	always @(posedge clk_in)
	begin
		up_one_r <= (start_one_in && !fail_one_in) ? up_one_r + (up_one_r != 2'h3) : 2'h0;
		up_two_r <= start_two_in ? up_two_r + (up_two_r != 2'h3) : 2'h0;
	end
	assign avail_one_out = up_one_r == 2'h3;
	assign avail_two_out = up_two_r == 2'h3;
endmodule

// ===== verif/genset_seq_tb.sv
// self-checking bench for the genset sequencer
`timescale 1ns/100ps
module genset_seq_tb;
	logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, req = 0, lead = 0, lamp = 0, fail = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, lfsr = 16'h0004;
	wire [15:0] rdata;
	wire s1, s2, c1, c2, a1, a2;
	wire [3:0] lamps;
	wire [3:0] o = {c2, c1, s2, s1};
	int miscompares = 0, n_tests = 0, i;
	genset_seq #(.TICK_DIV(10)) genset_seq_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
		.standby_start_request_in(req), .avail_one_in(a1), .avail_two_in(a2),
		.lead_test_in(lead), .lamp_test_in(lamp), .start_one_out(s1), .start_two_out(s2),
		.connect_one_out(c1), .connect_two_out(c2), .lamps_out(lamps));
	genset_pair_model genset_pair_model_i (.clk_in(clk_in), .start_one_in(s1),
		.start_two_in(s2), .fail_one_in(fail), .avail_one_out(a1), .avail_two_out(a2));
	initial
		forever #20 clk_in = ~clk_in;
	function [15:0] nxt(input [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function [15:0] hrs(input [15:0] x);
		return x > 16'h0150 ? 16'h0150 : x;
	endfunction
	task check(input [15:0] s, input [15:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge clk_in);
		wr_in <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr_in <= 0;
	endtask
	task rd(input [3:0] a, input [15:0] e);
		@(posedge clk_in);
		rd_in <= 1;
		addr <= a;
		@(posedge clk_in);
		rd_in <= 0;
		#1;
		check(rdata, e);
	endtask
	// elapsed edges must fall in lo..hi; one second is ten cycles here
	task wt(input [3:0] m, input [3:0] v, input int lo, input int hi);
		int t;
		t = 0;
		while ((o & m) !== v && t < 400)
		begin
			@(posedge clk_in);
			#1;
			t++;
		end
		check(t >= lo && t <= hi, 16'h0001);
	endtask
	task outage(input [1:0] s);
		@(posedge clk_in) req <= 1;
		wt({2'b00, s}, {2'b00, s}, 1, 3);
		wt({s, 2'b00}, {s, 2'b00}, 2, 6);
		@(posedge clk_in) req <= 0;
		wt(4'hF, 4'h0, 10, 40);
	endtask
	task report_and_stop;
		$display("miscompares %0d n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		miscompares++;
		report_and_stop;
	end
	initial
	begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1;
		#1;
		check(o, 4'h0);
		rd(4'h0, 16'h0003);
		rd(4'h1, 16'h0258);
		rd(4'h2, 16'h0258);
		rd(4'h4, 16'h0150);
		rd(4'h3, 16'h0000);
		rd(4'h6, 16'h0000);
		for (i = 0; i < 4; i++)
		begin
			lfsr = nxt(lfsr);
			wr(4'h4, lfsr);
			rd(4'h4, hrs(lfsr));
		end
		wr(4'h4, 16'h0151);
		rd(4'h4, 16'h0150);
		for (i = 0; i < 3; i++)
			wr(i, 16'h0002);
		@(posedge clk_in) lamp <= 1;
		#1;
		check(lamps, 4'hF);
		@(posedge clk_in) lamp <= 0;
		outage(2'h1);
		@(posedge clk_in) fail <= 1;
		@(posedge clk_in) req <= 1;
		wt(4'h2, 4'h2, 10, 40);
		wt(4'h8, 4'h8, 2, 6);
		rd(4'h3, 16'h0000);
		@(posedge clk_in) fail <= 0;
		wt(4'h4, 4'h4, 10, 60);
		wt(4'h2, 4'h0, 10, 40);
		wr(4'h3, 16'h0001);
		wt(4'h8, 4'h8, 2, 10);
		wt(4'h1, 4'h0, 10, 40);
		@(posedge clk_in) req <= 0;
		wt(4'hF, 4'h0, 10, 40);
		wr(4'h3, 16'h0002);
		outage(2'h1);
		outage(2'h2);
		rd(4'h3, 16'h0003);
		@(posedge clk_in) lead <= 1;
		@(posedge clk_in) lead <= 0;
		rd(4'h3, 16'h0002);
		outage(2'h2);
		report_and_stop;
	end
endmodule
